//--- rtl/tsc_tap.sv
// tap controller, instruction, bypass and data registers, all clocked by clock_i, with the pins sampled on it
module tsc_tap (
    input  wire logic                      clock_i,
    input  wire logic                      rst_n_i,
    input  wire logic                      tck_i,
    input  wire logic                      tms_i,
    input  wire logic                      tdi_i,
    input  wire logic [tsc_pkg::DR_W-1:0]  norm_in_i,
    output logic                           tdo_o,
    output logic                           tdo_oe_o,
    output logic      [tsc_pkg::DR_W-1:0]  norm_out_o,
    output logic      [tsc_pkg::IR_W-1:0]  instr_o,
    output logic      [3:0]                tap_state_o
);
    logic [tsc_pkg::SYNC_W-1:0] sync_w;
    logic                       tck_s;
    logic                       tms_s;
    logic                       tdi_s;
    logic [tsc_pkg::DR_W-1:0]   nin_s;
    logic                       tck_d_r;
    logic                       rise;
    logic                       fall;
    tsc_pkg::tsc_state_t        state_r;
    tsc_pkg::tsc_state_t        state_nxt;
    logic [tsc_pkg::IR_W-1:0]   ir_sh_r;
    logic                       byp_r;
    logic [tsc_pkg::DR_W-1:0]   dr_sh_r;
    logic                       bypass_sel;
    logic                       upd_ir_fall;
    logic                       upd_dr_fall;
    logic                       cap_dr_rise;
    logic                       sh_dr_rise;
    logic                       scan_bit;

    // shift states own the tdo driver; every other state keeps it off
    function automatic logic in_shift(input tsc_pkg::tsc_state_t st);
        return (st == tsc_pkg::TSC_SH_IR) || (st == tsc_pkg::TSC_SH_DR);
    endfunction

    // one scan stage: tdi enters at the msb, the lsb moves on towards tdo
    function automatic logic [tsc_pkg::DR_W-1:0] shift_in(
        input logic [tsc_pkg::DR_W-1:0] cur,
        input logic                     din
    );
        return {din, cur[tsc_pkg::DR_W-1:1]};
    endfunction

    // all pins share one synchroniser so tms, tdi and tck keep equal latency
    // edges show up two clocks after the pin moves, so tck must stay high and
    // low for at least one clock each; shorter phases are missed, not flagged
    tsc_sync #(
        .W (tsc_pkg::SYNC_W)
    ) u_sync (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .async_i ({tck_i, tms_i, tdi_i, norm_in_i}),
        .sync_o  (sync_w)
    );

    assign tck_s = sync_w[tsc_pkg::SYNC_W-1];
    assign tms_s = sync_w[tsc_pkg::SYNC_W-2];
    assign tdi_s = sync_w[tsc_pkg::SYNC_W-3];
    assign nin_s = sync_w[tsc_pkg::DR_W-1:0];

    // cleared like the idle pin, so reset release shows no false rise
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tck_d_r <= 1'b0;
        end else begin
            tck_d_r <= tck_s;
        end
    end

    // R1 rising edge sampling
    assign rise = tck_s & ~tck_d_r;
    // R2 falling edge updates
    assign fall = ~tck_s & tck_d_r;

    // R9 bypass decode
    assign bypass_sel = (instr_o == tsc_pkg::IR_BYPASS);

    // R12 R15 update strobes: the fall seen inside each update state
    assign upd_ir_fall = fall && (state_r == tsc_pkg::TSC_UPD_IR);
    assign upd_dr_fall = fall && (state_r == tsc_pkg::TSC_UPD_DR);

    // R13 R14 capture and shift strobes shared by both data stages
    assign cap_dr_rise = rise && (state_r == tsc_pkg::TSC_CAP_DR);
    assign sh_dr_rise  = rise && (state_r == tsc_pkg::TSC_SH_DR);

    // R16 tap state transitions
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tsc_pkg::TSC_TLR:    state_nxt = tms_s ? tsc_pkg::TSC_TLR    : tsc_pkg::TSC_RTI;
            tsc_pkg::TSC_RTI:    state_nxt = tms_s ? tsc_pkg::TSC_SEL_DR : tsc_pkg::TSC_RTI;
            // data column
            tsc_pkg::TSC_SEL_DR: state_nxt = tms_s ? tsc_pkg::TSC_SEL_IR : tsc_pkg::TSC_CAP_DR;
            tsc_pkg::TSC_CAP_DR: state_nxt = tms_s ? tsc_pkg::TSC_EX1_DR : tsc_pkg::TSC_SH_DR;
            tsc_pkg::TSC_SH_DR:  state_nxt = tms_s ? tsc_pkg::TSC_EX1_DR : tsc_pkg::TSC_SH_DR;
            tsc_pkg::TSC_EX1_DR: state_nxt = tms_s ? tsc_pkg::TSC_UPD_DR : tsc_pkg::TSC_PAU_DR;
            tsc_pkg::TSC_PAU_DR: state_nxt = tms_s ? tsc_pkg::TSC_EX2_DR : tsc_pkg::TSC_PAU_DR;
            tsc_pkg::TSC_EX2_DR: state_nxt = tms_s ? tsc_pkg::TSC_UPD_DR : tsc_pkg::TSC_SH_DR;
            tsc_pkg::TSC_UPD_DR: state_nxt = tms_s ? tsc_pkg::TSC_SEL_DR : tsc_pkg::TSC_RTI;
            // instruction column
            tsc_pkg::TSC_SEL_IR: state_nxt = tms_s ? tsc_pkg::TSC_TLR    : tsc_pkg::TSC_CAP_IR;
            tsc_pkg::TSC_CAP_IR: state_nxt = tms_s ? tsc_pkg::TSC_EX1_IR : tsc_pkg::TSC_SH_IR;
            tsc_pkg::TSC_SH_IR:  state_nxt = tms_s ? tsc_pkg::TSC_EX1_IR : tsc_pkg::TSC_SH_IR;
            tsc_pkg::TSC_EX1_IR: state_nxt = tms_s ? tsc_pkg::TSC_UPD_IR : tsc_pkg::TSC_PAU_IR;
            tsc_pkg::TSC_PAU_IR: state_nxt = tms_s ? tsc_pkg::TSC_EX2_IR : tsc_pkg::TSC_PAU_IR;
            tsc_pkg::TSC_EX2_IR: state_nxt = tms_s ? tsc_pkg::TSC_UPD_IR : tsc_pkg::TSC_SH_IR;
            tsc_pkg::TSC_UPD_IR: state_nxt = tms_s ? tsc_pkg::TSC_SEL_DR : tsc_pkg::TSC_RTI;
            default:             state_nxt = tsc_pkg::TSC_TLR;
        endcase
    end

    // the state moves only on a detected rise; between rises it holds
    // R18 tms-high path always lands in reset within five rises
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_r <= tsc_pkg::TSC_TLR;
        end else if (rise) begin
            state_r <= state_nxt;
        end
    end

    // state code mirrored one clock late so the port comes from a flop
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tap_state_o <= tsc_pkg::TSC_TLR;
        end else begin
            tap_state_o <= state_r;
        end
    end

    // R5 capture pattern, R7 R8 shift on each rise
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            ir_sh_r <= tsc_pkg::IR_CAPTURE;
        end else if (rise) begin
            if (state_r == tsc_pkg::TSC_CAP_IR) begin
                ir_sh_r <= tsc_pkg::IR_CAPTURE;
            end else if (state_r == tsc_pkg::TSC_SH_IR) begin
                ir_sh_r <= shift_in(ir_sh_r, tdi_s);
            end
        end
    end

    // R13 capture zero, R14 one-stage delay
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            byp_r <= tsc_pkg::BYP_CAPTURE;
        end else if (bypass_sel) begin
            if (cap_dr_rise) begin
                byp_r <= tsc_pkg::BYP_CAPTURE;
            end else if (sh_dr_rise) begin
                byp_r <= tdi_s;
            end
        end
    end

    // every instruction but bypass selects this eight-bit register
    // data register captures the normal inputs on the capture-dr rise
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            dr_sh_r <= tsc_pkg::DR_RESET;
        end else if (!bypass_sel) begin
            if (cap_dr_rise) begin
                dr_sh_r <= nin_s;
            end else if (sh_dr_rise) begin
                dr_sh_r <= shift_in(dr_sh_r, tdi_s);
            end
        end
    end

    // reloaded every clock in reset, not on an edge, so no edge can be missed
    // R12 instruction takes effect on the update-ir fall; reset state forces bypass
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            instr_o <= tsc_pkg::IR_BYPASS;
        end else if (state_r == tsc_pkg::TSC_TLR) begin
            instr_o <= tsc_pkg::IR_BYPASS;
        end else if (upd_ir_fall) begin
            instr_o <= ir_sh_r;
        end
    end

    // bypass leaves the outputs exactly as they were
    // R15 shifted data reaches the outputs on the update-dr fall
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            norm_out_o <= tsc_pkg::DR_RESET;
        end else if (upd_dr_fall && !bypass_sel) begin
            norm_out_o <= dr_sh_r;
        end
    end

    // R6 R11 R17 driver on only after falls in shift states
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tdo_oe_o <= 1'b0;
        end else if (fall) begin
            tdo_oe_o <= in_shift(state_r);
        end
    end

    // R14 bypass stage or register lsb feeds tdo
    always_comb begin
        scan_bit = dr_sh_r[0];
        if (state_r == tsc_pkg::TSC_SH_IR) begin
            scan_bit = ir_sh_r[0];
        end else if (bypass_sel) begin
            scan_bit = byp_r;
        end
    end

    // released pin keeps its last bit; only the pad driver lets go
    // R2 R8 tdo moves on falls only
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tdo_o <= 1'b0;
        end else if (fall && in_shift(state_r)) begin
            tdo_o <= scan_bit;
        end
    end
endmodule

//--- rtl/tsc_pkg.sv
// constants and types shared by the tap scan timing block
// Contract
// R1 - sample tdi, tms, inputs on tck rise
// R2 - tdo and outputs change on tck fall
// R3 - controller changes tms on tck fall
// R4 - controller drives tms low to leave reset
// R5 - capture-ir loads 10000001 into instruction register
// R6 - tdo driver enabled on fall entering shift
// R7 - first bit shifts on rise entering shift
// R8 - shift-ir moves one bit per rise
// R9 - all-ones instruction decodes as bypass
// R10 - controller raises tms on last shift
// R11 - tdo goes high impedance in exit1
// R12 - update-ir activates instruction on fall
// R13 - bypass register captures zero in capture-dr
// R14 - bypass delays tdi one stage
// R15 - update-dr transfers shifted data on fall
// R16 - standard sixteen state tap machine
// R17 - tdo off outside shift states
// R18 - five tms-high rises reach reset
package tsc_pkg;
    localparam int unsigned IR_W          = 8;
    localparam int unsigned DR_W          = 8;
    localparam int unsigned SYNC_W        = 2 + DR_W + 1;
    localparam logic [7:0]  IR_CAPTURE    = 8'h81;
    localparam logic [7:0]  IR_BYPASS     = 8'hFF;
    localparam logic [7:0]  DR_RESET      = 8'h00;
    localparam logic        BYP_CAPTURE   = 1'h0;

    typedef enum logic [3:0] {
        TSC_TLR, TSC_RTI,
        TSC_SEL_DR, TSC_CAP_DR, TSC_SH_DR, TSC_EX1_DR, TSC_PAU_DR, TSC_EX2_DR, TSC_UPD_DR,
        TSC_SEL_IR, TSC_CAP_IR, TSC_SH_IR, TSC_EX1_IR, TSC_PAU_IR, TSC_EX2_IR, TSC_UPD_IR
    } tsc_state_t;
endpackage

//--- rtl/tsc_sync.sv
// two-flop synchroniser for pins that arrive from outside the clock domain
module tsc_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end
endmodule

//--- bench/tsc_tap_properties.sv
// checker for the tap scan port timing
module tsc_tap_properties (
    input wire logic       clock_i,
    input wire logic       rst_n_i,
    input wire logic       tck_i,
    input wire logic       tdo_o,
    input wire logic       tdo_oe_o,
    input wire logic [7:0] norm_out_o,
    input wire logic [7:0] instr_o,
    input wire logic [3:0] tap_state_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    wire logic sh = tap_state_o == tsc_pkg::TSC_SH_IR || tap_state_o == tsc_pkg::TSC_SH_DR;
    wire logic ex = tap_state_o == tsc_pkg::TSC_EX1_IR || tap_state_o == tsc_pkg::TSC_EX1_DR;
    a_oe_in_shift: assert property ($rose(tdo_oe_o) |-> sh)
        else $error("tdo enabled outside shift");
    a_oe_off_exit: assert property ($fell(tdo_oe_o) |-> ex)
        else $error("tdo released outside exit1");
    a_tdo_on_fall: assert property ($changed(tdo_o) |-> !$past(tck_i, 2))
        else $error("tdo moved after a rise");
    a_state_on_rise: assert property ($changed(tap_state_o) |-> $past(tck_i, 2))
        else $error("state moved after a fall");
    a_ir_first_bit: assert property ($rose(tdo_oe_o) && sh && tap_state_o[3] |-> tdo_o)
        else $error("ir scan does not start with one");
    a_byp_first_bit: assert property ($rose(tdo_oe_o) && sh && !tap_state_o[3]
        && instr_o == 8'hFF |-> !tdo_o)
        else $error("bypass scan does not start with zero");
    a_instr_update: assert property ($changed(instr_o) && !$past(tck_i, 2)
        |-> tap_state_o == tsc_pkg::TSC_UPD_IR)
        else $error("instruction changed outside update-ir");
    a_norm_update: assert property ($changed(norm_out_o) |-> !$past(tck_i, 2)
        && tap_state_o == tsc_pkg::TSC_UPD_DR && instr_o != 8'hFF)
        else $error("outputs changed outside update-dr");
endmodule
bind tsc_tap tsc_tap_properties chk (.clock_i, .rst_n_i, .tck_i, .tdo_o, .tdo_oe_o,
    .norm_out_o, .instr_o, .tap_state_o);

//--- bench/tsc_ctrl_model.sv
// test controller model driving the scan pins
module tsc_ctrl_model (
    input  wire logic clock_i,
    input  wire logic tdo_i,
    input  wire logic tdo_oe_i,
    output logic      tck_o,
    output logic      tms_o,
    output logic      tdi_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
    end
    task automatic step(input logic ms, input logic di, output logic so, output logic oe);
        @(posedge clock_i);
        tck_o <= 1'b0;
        tms_o <= ms;
        tdi_o <= di;
        repeat (4) @(posedge clock_i);
        tck_o <= 1'b1;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        // a released pin reads as the inverse of its last bit
        so = tdo_oe_i ? tdo_i : ~tdo_i;
        oe = tdo_oe_i;
    endtask
endmodule

//--- bench/tsc_tap_bench.sv
// bench for the tap scan port: ir and dr scans, bypass, five-high reset
module tsc_tap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock_i, rst_n_i, tck, tms, tdi, tdo, tdo_oe, so, oe;
    logic [7:0] norm_in, norm_out, instr, got, v, d;
    logic [3:0] state;
    int         n_mismatch = 0;
    int         comparisons = 0;
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    tsc_tap uut (.clock_i, .rst_n_i, .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .norm_in_i(norm_in),
        .tdo_o(tdo), .tdo_oe_o(tdo_oe), .norm_out_o(norm_out), .instr_o(instr),
        .tap_state_o(state));
    tsc_ctrl_model ctrl (.clock_i, .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck), .tms_o(tms),
        .tdi_o(tdi));
    function automatic logic [7:0] byp_exp(input logic [7:0] x);
        return {x[6:0], 1'b0};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // from idle: select, capture, 8 shifts, exit1, update, back to idle
    task automatic scan(input bit ir, input logic [7:0] x);
        ctrl.step(1'b1, 1'b0, so, oe);
        if (ir)
            ctrl.step(1'b1, 1'b0, so, oe);
        ctrl.step(1'b0, 1'b0, so, oe);
        ctrl.step(1'b0, 1'b0, so, oe);
        for (int k = 0; k < 8; k++) begin
            ctrl.step(k == 7, x[k], so, oe);
            got[k] = so;
            check({7'h00, oe}, 8'h01);
        end
        ctrl.step(1'b1, 1'b0, so, oe);
        check({7'h00, oe}, 8'h00);
        ctrl.step(1'b0, 1'b0, so, oe);
    endtask
    initial begin
        rst_n_i = 1'b0;
        norm_in = 8'h00;
        void'($urandom(63175));
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(negedge clock_i);
        check({4'h0, state}, 8'h00);
        check(instr, 8'hFF);
        ctrl.step(1'b0, 1'b0, so, oe);
        for (int t = 0; t < 3; t++) begin
            v = 8'($urandom_range(0, 254));
            scan(1'b1, v);
            check(got, 8'h81);
            check(instr, v);
            @(posedge clock_i);
            norm_in <= 8'($urandom);
            d = 8'($urandom);
            scan(1'b0, d);
            check(got, norm_in);
            check(norm_out, d);
            ctrl.step(1'b1, 1'b0, so, oe);
            ctrl.step(1'b0, 1'b0, so, oe);
            ctrl.step(1'b0, 1'b0, so, oe);
            repeat (5) ctrl.step(1'b1, 1'b0, so, oe);
            repeat (2) @(negedge clock_i);
            check({4'h0, state}, 8'h00);
            // the walk to reset captured, shifted one zero in and passed update-dr
            d = {1'b0, norm_in[7:1]};
            check(norm_out, d);
            check(instr, 8'hFF);
            ctrl.step(1'b0, 1'b0, so, oe);
            scan(1'b1, 8'hFF);
            check(got, 8'h81);
            check(instr, 8'hFF);
            v = 8'($urandom);
            scan(1'b0, v);
            check(got, byp_exp(v));
            check(norm_out, d);
            $display("trial %0d done", t);
        end
        complete_run();
    end
    initial begin
        repeat (6000) @(posedge clock_i);
        n_mismatch++;
        $display("Error %0t: watchdog expired", $time);
        complete_run();
    end
endmodule
